/* File: hdl/prrp_device.sv */
`timescale 1ns/1ps
`default_nettype none
module prrp_device
	import prrp_pkg::*;
#(
	parameter int N_IF = 1
) (
	input  wire logic            CLK,
	input  wire logic            SRST,
	input  wire logic            CE,
	prrp_if.device               LINK,
	input  wire logic            TXEQ_GO,
	input  wire logic [prrp_pkg::SEL_W-1:0]  TAP_SEL_IN,
	input  wire logic [prrp_pkg::MAIN_W-1:0] MAIN_IN,
	input  wire logic [prrp_pkg::POST_W-1:0] POST_IN,
	input  wire logic [prrp_pkg::PRE_W-1:0]  PRE_IN,
	input  wire logic            PCS_GO,
	input  wire logic [prrp_pkg::MODE_W-1:0] MODE_IN,
	input  wire logic            DFE_GO,
	input  wire logic [prrp_pkg::OP_W-1:0]   DFE_OP_IN,
	input  wire logic            LIN_GO,
	input  wire logic [prrp_pkg::OP_W-1:0]   LIN_OP_IN,
	input  wire logic [prrp_pkg::LIN_W-1:0]  LIN_VAL_IN,
	input  wire logic            AUTO_SPEED_EN,
	input  wire logic            AUTO_SPEED_1G,
	output logic                 REQ_READY,
	output logic                 REQ_REFUSED,
	output logic                 SPEED_1G,
	output logic                 LT_ALLOWED
);
	import prrp_pkg::*;

	// Packed operand words held by the start-and-hold cells
	localparam int TXEQ_W = SEL_W + MAIN_W + POST_W + PRE_W;
	localparam int LIN_OPW = OP_W + LIN_W;

	logic                  any_active;
	logic [3:0]            act;
	logic                  tx_go, pcs_go, dfe_go, lin_go;
	logic                  sel_ok, mode_ok, dfe_ok, lin_ok;
	logic [TXEQ_W-1:0]     txeq_data;
	logic [LIN_OPW-1:0]    lin_data;
	logic                  refused_q, refused_d;
	logic                  speed_q, speed_d;

	if (N_IF != 1) begin : g_n_if_check
		$error("prrp_device: only one reconfiguration interface is served");
	end

	// Legal operands only
	always_comb begin
		case (TAP_SEL_IN)
			SEL_MAIN: sel_ok = 1'b1;
			SEL_POST: sel_ok = 1'b1;
			SEL_PRE:  sel_ok = 1'b1;
			default:  sel_ok = 1'b0;
		endcase
		case (MODE_IN)
			MODE_AN:     mode_ok = 1'b1;
			MODE_LT:     mode_ok = 1'b1;
			MODE_KR:     mode_ok = 1'b1;
			MODE_GIGE:   mode_ok = 1'b1;
			MODE_KR_FEC: mode_ok = 1'b1;
			default:     mode_ok = 1'b0; // Reserved, all-zero and multi-hot codes
		endcase
		case (DFE_OP_IN)
			DFE_OFF:       dfe_ok = 1'b1;
			DFE_TRIGGERED: dfe_ok = 1'b1;
			default:       dfe_ok = 1'b0;
		endcase
		case (LIN_OP_IN)
			LIN_FROM_LT: lin_ok = 1'b1;
			default:     lin_ok = 1'b0;
		endcase
	end

	// One request at a time; priority tx-eq, pcs, dfe, linear
	assign any_active = |act || LINK.reconfig_in_progress;
	assign REQ_READY  = !any_active;

	always_comb begin
		tx_go  = 1'b0;
		pcs_go = 1'b0;
		dfe_go = 1'b0;
		lin_go = 1'b0;
		if (REQ_READY) begin
			if (TXEQ_GO) begin
				tx_go = sel_ok && LT_ALLOWED;
			end else if (PCS_GO) begin
				pcs_go = mode_ok;
			end else if (DFE_GO) begin
				dfe_go = dfe_ok;
			end else if (LIN_GO) begin
				lin_go = lin_ok;
			end
		end
	end

	// A cycle with a go but no request taken is reported one cycle later
	always_comb begin
		refused_d = (TXEQ_GO || PCS_GO || DFE_GO || LIN_GO)
			&& !(tx_go || pcs_go || dfe_go || lin_go);
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			refused_q <= 1'b0;
		end else if (CE) begin
			refused_q <= refused_d;
		end
	end

	// Auto speed result wins while its sequencer is enabled
	always_comb begin
		if (AUTO_SPEED_EN) begin
			speed_d = AUTO_SPEED_1G;
		end else begin
			speed_d = LINK.speed_request;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			speed_q <= 1'b0;
		end else if (CE) begin
			speed_q <= speed_d;
		end
	end

	assign REQ_REFUSED = refused_q;
	assign SPEED_1G    = speed_q;
	assign LT_ALLOWED  = LINK.rx_eq_done;

	prrp_start_hold #(.W(TXEQ_W)) u_txeq (
		.clk      (CLK),
		.srst     (SRST),
		.ce       (CE),
		.go       (tx_go),
		.data_in  ({TAP_SEL_IN, MAIN_IN, POST_IN, PRE_IN}),
		.busy     (LINK.reconfig_in_progress),
		.start    (LINK.tx_eq_update_request),
		.data_out (txeq_data),
		.active   (act[0])
	);
	// Main, post and pre taps held with their selector
	assign {LINK.tap_select, LINK.main_tap_value, LINK.post_tap_value, LINK.pre_tap_value} = txeq_data;

	prrp_start_hold #(.W(MODE_W)) u_pcs (
		.clk      (CLK),
		.srst     (SRST),
		.ce       (CE),
		.go       (pcs_go),
		.data_in  (MODE_IN),
		.busy     (LINK.reconfig_in_progress),
		.start    (LINK.pcs_reconfig_request),
		.data_out (LINK.pcs_mode),
		.active   (act[1])
	);

	prrp_start_hold #(.W(OP_W)) u_dfe (
		.clk      (CLK),
		.srst     (SRST),
		.ce       (CE),
		.go       (dfe_go),
		.data_in  (DFE_OP_IN),
		.busy     (LINK.reconfig_in_progress),
		.start    (LINK.feedback_eq_request),
		.data_out (LINK.feedback_eq_op),
		.active   (act[2])
	);

	prrp_start_hold #(.W(LIN_OPW)) u_lin (
		.clk      (CLK),
		.srst     (SRST),
		.ce       (CE),
		.go       (lin_go),
		.data_in  ({LIN_OP_IN, LIN_VAL_IN}),
		.busy     (LINK.reconfig_in_progress),
		.start    (LINK.linear_eq_request),
		.data_out (lin_data),
		.active   (act[3])
	);
	assign {LINK.linear_eq_op, LINK.linear_eq_value} = lin_data;

	// Only one interface is served, so the outbound bundle carries nothing
	assign LINK.rx_eq_enable        = 1'b0;
	assign LINK.reconfig_bundle_out = '0;
endmodule
`default_nettype wire

/* File: hdl/prrp_pkg.sv */
package prrp_pkg;
	localparam int BUNDLE_IN_W  = 70;
	localparam int BUNDLE_OUT_W = 46;
	localparam int MAIN_W       = 6;
	localparam int POST_W       = 5;
	localparam int PRE_W        = 4;
	localparam int SEL_W        = 3;
	localparam int MODE_W       = 6;
	localparam int OP_W         = 2;
	localparam int LIN_W        = 4;
	localparam logic [SEL_W-1:0] SEL_MAIN = 3'h4;
	localparam logic [SEL_W-1:0] SEL_POST = 3'h2;
	localparam logic [SEL_W-1:0] SEL_PRE  = 3'h1;
	localparam logic [MODE_W-1:0] MODE_AN      = 6'h01;
	localparam logic [MODE_W-1:0] MODE_LT      = 6'h02;
	localparam logic [MODE_W-1:0] MODE_KR      = 6'h04;
	localparam logic [MODE_W-1:0] MODE_GIGE    = 6'h08;
	localparam logic [MODE_W-1:0] MODE_RSVD    = 6'h10;
	localparam logic [MODE_W-1:0] MODE_KR_FEC  = 6'h20;
	localparam logic [OP_W-1:0] DFE_OFF       = 2'h0;
	localparam logic [OP_W-1:0] DFE_TRIGGERED = 2'h1;
	localparam logic [OP_W-1:0] LIN_FROM_LT   = 2'h0;
	// Request kinds
	localparam logic [1:0] KIND_TXEQ = 2'h0;
	localparam logic [1:0] KIND_PCS  = 2'h1;
	localparam logic [1:0] KIND_DFE  = 2'h2;
	localparam logic [1:0] KIND_LIN  = 2'h3;
	// Controller register map (word byte addresses)
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_REQ    = 4'h8;
	localparam logic [3:0] ADDR_COUNT  = 4'hC;
	localparam int CTRL_SPEED_BIT   = 0;
	localparam int CTRL_EQDONE_BIT  = 1;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_PEND_BIT    = 1;
	localparam int STAT_RXEQEN_BIT  = 2;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0002;
	// Controller busy time in cycles
	localparam int WORK_CYCLES = 8;
	typedef enum logic [1:0] {
		PRRP_IDLE = 2'b00,
		PRRP_REQ  = 2'b01,
		PRRP_WAIT = 2'b11
	} prrp_state_t;
endpackage

/* File: hdl/prrp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface prrp_if;
	import prrp_pkg::*;
	logic                    reconfig_in_progress;
	logic                    tx_eq_update_request;
	logic [MAIN_W-1:0]       main_tap_value;
	logic [POST_W-1:0]       post_tap_value;
	logic [PRE_W-1:0]        pre_tap_value;
	logic [SEL_W-1:0]        tap_select;
	logic                    pcs_reconfig_request;
	logic [MODE_W-1:0]       pcs_mode;
	logic                    feedback_eq_request;
	logic [OP_W-1:0]         feedback_eq_op;
	logic                    linear_eq_request;
	logic [OP_W-1:0]         linear_eq_op;
	logic [LIN_W-1:0]        linear_eq_value;
	logic                    speed_request;
	logic                    rx_eq_enable;
	logic                    rx_eq_done;
	logic [BUNDLE_IN_W-1:0]  reconfig_bundle_in;
	logic [BUNDLE_OUT_W-1:0] reconfig_bundle_out;
	modport device (
		input  reconfig_in_progress, speed_request, rx_eq_done, reconfig_bundle_in,
		output tx_eq_update_request, main_tap_value, post_tap_value, pre_tap_value, tap_select,
		output pcs_reconfig_request, pcs_mode, feedback_eq_request, feedback_eq_op,
		output linear_eq_request, linear_eq_op, linear_eq_value, rx_eq_enable, reconfig_bundle_out
	);
	modport ctrl (
		output reconfig_in_progress, speed_request, rx_eq_done, reconfig_bundle_in,
		input  tx_eq_update_request, main_tap_value, post_tap_value, pre_tap_value, tap_select,
		input  pcs_reconfig_request, pcs_mode, feedback_eq_request, feedback_eq_op,
		input  linear_eq_request, linear_eq_op, linear_eq_value, rx_eq_enable, reconfig_bundle_out
	);
endinterface
`default_nettype wire

/* File: hdl/prrp_start_hold.sv */
`timescale 1ns/1ps
`default_nettype none
// One start output with its held operands: raised on a one-cycle go, dropped once
// busy is seen high, operands held until busy falls.
module prrp_start_hold #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         ce,
	input  wire logic         go,
	input  wire logic [W-1:0] data_in,
	input  wire logic         busy,
	output logic              start,
	output logic [W-1:0]      data_out,
	output logic              active
);
	logic         start_q, start_d;
	logic         act_q, act_d;
	logic         seen_q, seen_d;
	logic [W-1:0] data_q, data_d;

	if (W < 1) begin : g_w_check
		$error("prrp_start_hold: W must be positive");
	end

	always_comb begin
		start_d = start_q;
		act_d   = act_q;
		seen_d  = seen_q;
		data_d  = data_q;
		if (!act_q && go) begin
			data_d  = data_in;
			start_d = 1'b1;
			act_d   = 1'b1;
			seen_d  = 1'b0;
		end else if (act_q) begin
			if (busy) begin
				start_d = 1'b0;
				seen_d  = 1'b1;
			end else if (seen_q) begin
				act_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			start_q <= 1'b0;
			act_q   <= 1'b0;
			seen_q  <= 1'b0;
			data_q  <= '0;
		end else if (ce) begin
			start_q <= start_d;
			act_q   <= act_d;
			seen_q  <= seen_d;
			data_q  <= data_d;
		end
	end

	assign start    = start_q;
	assign data_out = data_q;
	assign active   = act_q;
endmodule
`default_nettype wire

/* File: hdl/prrp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module prrp_ctrl
	import prrp_pkg::*;
#(
	parameter int BUSY_CYCLES = prrp_pkg::WORK_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        CE,
	prrp_if.ctrl             LINK,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             CH_RESET
);
	import prrp_pkg::*;

	prrp_state_t  st_q, st_d;
	logic [7:0]   cnt_q, cnt_d;
	logic [1:0]   kind_q, kind_d;
	logic [15:0]  done_q, done_d;
	logic [31:0]  ctrl_q, ctrl_d;
	logic         ack_q, ack_d;
	logic [31:0]  dat_q, dat_d;
	logic         rst_q, rst_d;
	logic         any_req;
	logic         wr;

	if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_busy_check
		$error("prrp_ctrl: BUSY_CYCLES out of range");
	end

	assign any_req = LINK.tx_eq_update_request || LINK.pcs_reconfig_request
		|| LINK.feedback_eq_request || LINK.linear_eq_request;
	// A write lands at the edge where the master sees ack high
	assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		kind_d = kind_q;
		done_d = done_q;
		rst_d  = 1'b0;
		case (st_q)
			PRRP_IDLE: begin
				if (any_req) begin
					st_d  = PRRP_REQ;
					cnt_d = 8'(BUSY_CYCLES);
					kind_d = LINK.tx_eq_update_request ? KIND_TXEQ :
						LINK.pcs_reconfig_request ? KIND_PCS :
						LINK.feedback_eq_request ? KIND_DFE : KIND_LIN;
				end
			end
			PRRP_REQ: begin
				// Busy high while the work runs
				if (cnt_q == 8'h01) begin
					st_d = PRRP_WAIT;
				end
				cnt_d = cnt_q - 8'h01;
			end
			PRRP_WAIT: begin
				// Busy has fallen; pulse channel reset once
				st_d   = PRRP_IDLE;
				rst_d  = 1'b1;
				done_d = done_q + 16'h0001;
			end
			default: begin
				st_d = PRRP_IDLE;
			end
		endcase
	end

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr && WB_ADR_I == ADDR_CTRL && WB_SEL_I[0]) begin
			ctrl_d[7:0] = WB_DAT_I[7:0];
		end
		ack_d = WB_CYC_I && WB_STB_I && !ack_q;
		case (WB_ADR_I)
			ADDR_CTRL:   dat_d = ctrl_q;
			ADDR_STATUS: dat_d = {29'h0000_0000, LINK.rx_eq_enable, any_req, LINK.reconfig_in_progress};
			ADDR_REQ:    dat_d = {16'h0000, LINK.pcs_mode, kind_q, LINK.tap_select, 5'h00};
			ADDR_COUNT:  dat_d = {16'h0000, done_q};
			default:     dat_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			st_q   <= PRRP_IDLE;
			cnt_q  <= 8'h00;
			kind_q <= 2'h0;
			done_q <= 16'h0000;
			ctrl_q <= CTRL_RESET;
			ack_q  <= 1'b0;
			dat_q  <= 32'h0000_0000;
			rst_q  <= 1'b0;
		end else if (CE) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			kind_q <= kind_d;
			done_q <= done_d;
			ctrl_q <= ctrl_d;
			ack_q  <= ack_d;
			dat_q  <= dat_d;
			rst_q  <= rst_d;
		end
	end

	assign LINK.reconfig_in_progress = (st_q == PRRP_REQ);
	assign LINK.speed_request        = ctrl_q[CTRL_SPEED_BIT];
	assign LINK.rx_eq_done           = ctrl_q[CTRL_EQDONE_BIT];
	assign LINK.reconfig_bundle_in   = '0;
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;
	assign CH_RESET = rst_q;
endmodule
`default_nettype wire

/* File: test/prrp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module prrp_monitor #(
	parameter int BUSY_CYCLES = 4
) (
	input wire logic       CLK,
	input wire logic       SRST,
	input wire logic       reconfig_in_progress,
	input wire logic       tx_eq_update_request,
	input wire logic       pcs_reconfig_request,
	input wire logic       feedback_eq_request,
	input wire logic       linear_eq_request,
	input wire logic [2:0] tap_select,
	input wire logic [5:0] pcs_mode,
	input wire logic [1:0] feedback_eq_op,
	input wire logic [1:0] linear_eq_op,
	input wire logic [3:0] linear_eq_value,
	input wire logic       rx_eq_done,
	input wire logic       rx_eq_enable
);
	logic [3:0] rq;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	assign rq = {linear_eq_request, feedback_eq_request, pcs_reconfig_request, tx_eq_update_request};
	// Cycles of busy seen so far
	always_comb begin
		cnt_d = reconfig_in_progress ? cnt_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge CLK) begin
		cnt_q <= SRST ? 8'h00 : cnt_d;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_one_start: assert property ($onehot0(rq)) else $error("two starts");
	a_start_idle: assert property ($rose(|rq) |-> !reconfig_in_progress) else $error("start while busy");
	a_start_drop: assert property ($rose(reconfig_in_progress) |=> rq == 4'h0) else $error("start kept");
	a_busy_answer: assert property ($rose(|rq) |=> $rose(reconfig_in_progress)) else $error("no busy");
	a_busy_len: assert property ($fell(reconfig_in_progress) |-> cnt_q == BUSY_CYCLES) else $error("busy len");
	a_tap_onehot: assert property (tx_eq_update_request |-> tap_select inside {3'h4, 3'h2, 3'h1})
		else $error("bad tap select");
	a_mode_legal: assert property (pcs_reconfig_request |-> $onehot(pcs_mode) && !pcs_mode[4])
		else $error("bad mode");
	a_dfe_legal: assert property (feedback_eq_request |-> !feedback_eq_op[1]) else $error("bad dfe op");
	a_lin_legal: assert property (linear_eq_request |-> linear_eq_op == 2'h0) else $error("bad lin op");
	a_dfe_held: assert property ($past(reconfig_in_progress) || $past(feedback_eq_request) |->
		$stable(feedback_eq_op)) else $error("dfe op moved");
	a_lin_held: assert property ($past(reconfig_in_progress) || $past(linear_eq_request) |->
		$stable({linear_eq_op, linear_eq_value})) else $error("lin moved");
	a_lt_gate: assert property ($rose(tx_eq_update_request) |-> $past(rx_eq_done)) else $error("lt gate");
	a_eq_en_off: assert property (!rx_eq_enable) else $error("eq enable driven");
	cover property ($fell(reconfig_in_progress));
	cover property (pcs_reconfig_request && pcs_mode == 6'h20);
	cover property (linear_eq_request && linear_eq_value == 4'hF);
endmodule
`default_nettype wire

/* File: test/phy_reconfig_request_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_reconfig_request_port_bench import prrp_pkg::*;;
	localparam int BC = 4;
	logic clk, srst, ce, aen, a1g, cyc, stb, we;
	logic [3:0] go, rtap, lval, adr, sel;
	logic [2:0] tsel;
	logic [5:0] mtap, mode;
	logic [4:0] ptap;
	logic [1:0] dop, lop;
	logic [31:0] wd, rd;
	wire logic rdy, refd, sp1g, lt_ok, ack, chr;
	wire logic [31:0] rdat;
	wire logic [3:0] rqs;
	int bad_count, num_checks, seed, dn, cyc_n;
	prrp_if link();
	assign rqs = {link.linear_eq_request, link.feedback_eq_request, link.pcs_reconfig_request,
		link.tx_eq_update_request};
	prrp_device i_prrp_device (.CLK(clk), .SRST(srst), .CE(ce), .LINK(link), .TXEQ_GO(go[0]),
		.TAP_SEL_IN(tsel), .MAIN_IN(mtap), .POST_IN(ptap), .PRE_IN(rtap), .PCS_GO(go[1]), .MODE_IN(mode),
		.DFE_GO(go[2]), .DFE_OP_IN(dop), .LIN_GO(go[3]), .LIN_OP_IN(lop), .LIN_VAL_IN(lval),
		.AUTO_SPEED_EN(aen), .AUTO_SPEED_1G(a1g), .REQ_READY(rdy), .REQ_REFUSED(refd), .SPEED_1G(sp1g),
		.LT_ALLOWED(lt_ok));
	prrp_ctrl #(.BUSY_CYCLES(BC)) i_prrp_ctrl (.CLK(clk), .SRST(srst), .CE(ce), .LINK(link),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .CH_RESET(chr));
	prrp_monitor #(.BUSY_CYCLES(BC)) i_prrp_monitor (.CLK(clk), .SRST(srst),
		.reconfig_in_progress(link.reconfig_in_progress), .tx_eq_update_request(link.tx_eq_update_request),
		.pcs_reconfig_request(link.pcs_reconfig_request), .feedback_eq_request(link.feedback_eq_request),
		.linear_eq_request(link.linear_eq_request), .tap_select(link.tap_select), .pcs_mode(link.pcs_mode),
		.feedback_eq_op(link.feedback_eq_op), .linear_eq_op(link.linear_eq_op),
		.linear_eq_value(link.linear_eq_value), .rx_eq_done(link.rx_eq_done), .rx_eq_enable(link.rx_eq_enable));
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wd, sel} <= {2'h3, w, a, d, 4'hF};
		do begin
			@(negedge clk);
		end while (ack !== 1'h1);
		rd = rdat;
		@(posedge clk);
		{cyc, stb} <= 2'h0;
	endtask
	function automatic logic want_ok(input int k, input logic [5:0] c);
		case (k)
		0: return c[2:0] inside {SEL_MAIN, SEL_POST, SEL_PRE};
		1: return $onehot(c) && c != MODE_RSVD;
		default: return c[5:2] == 4'h0 && c[1:0] < (k == 2 ? 2 : 1);
		endcase
	endfunction
	task automatic issue(input int k, input logic [5:0] c, input logic en);
		logic ok;
		logic [7:0] h, r;
		ok = en && want_ok(k, c);
		h = 8'h00;
		r = 8'h00;
		@(negedge clk);
		while (rdy !== 1'h1) begin
			@(negedge clk);
		end
		@(posedge clk);
		go[k] <= 1'h1;
		@(posedge clk);
		go <= 4'h0;
		@(negedge clk);
		check(rqs, ok ? 32'h1 << k : 32'h0);
		check(refd, !ok);
		if (ok) begin
			case (k)
			0: check({link.tap_select, link.main_tap_value, link.post_tap_value, link.pre_tap_value},
				{tsel, mtap, ptap, rtap});
			1: check(link.pcs_mode, mode);
			2: check(link.feedback_eq_op, dop);
			default: check({link.linear_eq_op, link.linear_eq_value}, {lop, lval});
			endcase
			@(posedge clk);
			go[k] <= 1'h1;
			@(posedge clk);
			go <= 4'h0;
			repeat (BC + 6) begin
				@(negedge clk);
				h = h + chr;
				r = r + refd;
			end
			check(h, 1);
			check(r, 1);
			check(rdy, 1);
			dn++;
		end
		@(posedge clk);
	endtask
	initial begin
		logic [5:0] t;
		{srst, go, aen, a1g, cyc, stb, we, adr, sel, wd, tsel, mtap, ptap, rtap, mode, dop, lop, lval} = 1;
		srst = 1'h1;
		ce = 1'h1;
		{bad_count, num_checks, dn, cyc_n} = 0;
		seed = 34915;
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		check($bits(link.reconfig_bundle_in), 70);
		check($bits(link.reconfig_bundle_out), 46);
		wb(0, ADDR_CTRL, 0);
		check(rd, CTRL_RESET);
		wb(0, 4'h2, 0);
		check(rd, 0);
		for (int i = 0; i < 7; i++) begin
			t = i < 6 ? SEL_MAIN >> (i % 3) : 3'h3;
			tsel <= t[2:0];
			mtap <= i == 0 ? 6'h3F : i == 1 ? 6'h00 : 6'($random(seed));
			ptap <= i == 0 ? 5'h1F : i == 1 ? 5'h00 : 5'($random(seed));
			rtap <= i == 0 ? 4'hF : i == 1 ? 4'h0 : 4'($random(seed));
			issue(0, t, 1);
		end
		for (int i = 0; i < 7; i++) begin
			t = i < 6 ? 6'h01 << i : 6'h03;
			mode <= t;
			issue(1, t, 1);
		end
		wb(0, ADDR_REQ, 0);
		check(rd, {16'h0000, MODE_KR_FEC, KIND_PCS, SEL_PRE, 5'h00});
		for (int i = 0; i < 4; i++) begin
			dop <= 2'(i);
			issue(2, 6'(i), 1);
		end
		for (int i = 0; i < 5; i++) begin
			t = i < 4 ? 6'(i) : 6'h00;
			lop <= t[1:0];
			lval <= i == 0 ? 4'hF : i == 4 ? 4'h0 : 4'($random(seed));
			issue(3, t, 1);
		end
		wb(1, ADDR_CTRL, 32'h0000_0001);
		@(negedge clk);
		check(lt_ok, 0);
		check(link.speed_request, 1);
		@(posedge clk);
		tsel <= SEL_PRE;
		issue(0, 6'h01, 0);
		repeat (2) @(posedge clk);
		check(sp1g, 1);
		aen <= 1'h1;
		repeat (2) @(posedge clk);
		check(sp1g, 0);
		wb(1, ADDR_CTRL, CTRL_RESET);
		aen <= 1'h0;
		// Clock enable low freezes the request path
		mode <= MODE_AN;
		ce <= 1'h0;
		go[1] <= 1'h1;
		repeat (3) @(posedge clk);
		go <= 4'h0;
		@(negedge clk);
		check(rqs, 0);
		@(posedge clk);
		ce <= 1'h1;
		wb(0, ADDR_STATUS, 0);
		check(rd, 0);
		wb(0, ADDR_COUNT, 0);
		check(rd, dn);
		end_sim();
	end
endmodule
`default_nettype wire
